//--- dv/ddr4_bank_refresh_ctl_tb.sv
`default_nettype none
module ddr4_bank_refresh_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, resetn = 0, reqValid = 0, reqReady; // clock, reset, request
  ddr4_ctl_pkg::cmd_e reqCmd = ddr4_ctl_pkg::CMD_PRE;    // request command
  logic [1:0] reqBg = '0, reqBa = '0, refMode = '0;      // bank, mode
  logic [17:0] reqRow = '0;                              // row
  logic [15:0] bankOpen;                                 // open rows
  logic signed [6:0] postponed;                          // owed refreshes
  logic srActive, readOk, ckT, ckC, cke, csN, actN, ras, cas, we, a17; // pins
  logic [13:0] addr;                                     // address pins
  logic [1:0] bg, ba;                                    // bank pins
  logic [15:0] devOpen;                                  // model open rows
  logic [17:0] devRow;                                   // model last row
  logic [3:0] devBank;                                   // model last bank
  int nRef, nErr, nInt, n_fail = 0, n_compared = 0, cycles = 0; // counters
  logic srMode, termOn, dllOn;                           // model state
  bit took;                                              // request taken
  logic odt, rstN;                                       // termination, device reset
  always #2 core_clk = ~core_clk;
  ddr4_bank_refresh_ctl dut_u (.core_clk(core_clk), .resetn(resetn), .reqValid(reqValid),
    .reqReady(reqReady), .reqCmd(reqCmd), .reqBg(reqBg), .reqBa(reqBa), .reqRow(reqRow),
    .refMode(refMode), .bankOpen(bankOpen), .postponed(postponed), .srActive(srActive),
    .readOk(readOk), .ddrCkT(ckT), .ddrCkC(ckC), .ddrCke(cke), .ddrCsN(csN), .ddrActN(actN),
    .ddrRasNA16(ras), .ddrCasNA15(cas), .ddrWeNA14(we), .ddrA17(a17), .ddrAddr(addr),
    .ddrBg(bg), .ddrBa(ba), .ddrOdt(odt), .ddrResetN(rstN));
  ddr4_dev_model dev (.ckT(ckT), .cke(cke), .csN(csN), .actN(actN),
    .row({a17, ras, cas, we, addr}), .bank({bg, ba}), .rowOpen(devOpen), .lastRow(devRow),
    .lastBank(devBank), .nRef(nRef), .nErr(nErr), .nInt(nInt), .srMode(srMode),
    .termOn(termOn), .dllOn(dllOn));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin n_fail++; $display("MISMATCH %0t %s", $time, m); end
  endtask
  // offer a request for at most lim cycles; ready is settled 1 ns after the fall
  task automatic send(input ddr4_ctl_pkg::cmd_e c, input logic [3:0] bk,
                      input logic [17:0] r, input int lim);
    took = 0;
    @(negedge core_clk);
    reqCmd = c; reqBg = bk[3:2]; reqBa = bk[1:0]; reqRow = r; reqValid = 1;
    for (int i = 0; i < lim && !took; i++)
    begin
      #1 took = (reqReady === 1'b1);
      @(negedge core_clk);
    end
    reqValid = 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(bankOpen === 16'h0 && postponed === 7'sh0 && cke === 1'b1, "reset state");
    chk(readOk === 1'b1 && srActive === 1'b0 && rstN === 1'b1 && odt === 1'b0, "reset pins");
  endtask
  task automatic t_act_pre;
    send(ddr4_ctl_pkg::CMD_ACT, 4'h6, 18'h2A5C3, 40);
    idle(12);
    chk(took && devBank === 4'h6 && devRow === 18'h2A5C3, "act decode");
    chk(bankOpen === 16'h0040, "open bit");
    send(ddr4_ctl_pkg::CMD_ACT, 4'h6, 18'h00011, 40);
    chk(!took, "act to open bank taken");
    send(ddr4_ctl_pkg::CMD_PRE, 4'h6, 18'h0, 40);
    send(ddr4_ctl_pkg::CMD_PRE, 4'h6, 18'h0, 40);
    chk(took && bankOpen === 16'h0, "repeat precharge");
    send(ddr4_ctl_pkg::CMD_ACT, 4'h6, 18'h00011, 60);
    idle(12);
    chk(took && devRow === 18'h00011 && nErr == 0, "reactivate timing");
    send(ddr4_ctl_pkg::CMD_PREA, 4'h0, 18'h0, 40);
  endtask
  task automatic t_refresh;
    int r0;
    logic signed [6:0] p0;
    r0 = nRef;
    p0 = postponed;
    send(ddr4_ctl_pkg::CMD_REF, 4'h0, 18'h0, 60);
    send(ddr4_ctl_pkg::CMD_ACT, 4'h1, 18'h00005, 40);
    chk(took === 1'b0, "command inside refresh busy");
    chk(nRef == r0 + 1 && postponed === p0 - 7'sh1, "refresh count");
    send(ddr4_ctl_pkg::CMD_ACT, 4'h1, 18'h00005, 200);
    send(ddr4_ctl_pkg::CMD_REF, 4'h0, 18'h0, 40);
    chk(!took && nErr == 0, "refresh with open bank");
    send(ddr4_ctl_pkg::CMD_PREA, 4'h0, 18'h0, 40);
  endtask
  task automatic t_selfref;
    send(ddr4_ctl_pkg::CMD_SRE, 4'h0, 18'h0, 60);
    idle(40);
    chk(took && cke === 1'b0 && srActive === 1'b1 && srMode, "entry");
    chk(!termOn && !dllOn && nInt == 1, "device low power");
    chk(ckT === 1'b0 && ckC === 1'b1, "clock stopped");
    send(ddr4_ctl_pkg::CMD_SRX, 4'h0, 18'h0, 60);
    for (int i = 0; i < 60 && cke !== 1'b1; i++) idle(1);
    idle(2);
    chk(cke === 1'b1 && readOk === 1'b0 && !srMode && dllOn, "exit");
    send(ddr4_ctl_pkg::CMD_SRE, 4'h0, 18'h0, 200);
    chk(!took, "reentry without refresh");
    send(ddr4_ctl_pkg::CMD_REF, 4'h0, 18'h0, 200);
    send(ddr4_ctl_pkg::CMD_SRE, 4'h0, 18'h0, 200);
    chk(took && nErr == 0, "reentry after refresh");
    idle(40);
    send(ddr4_ctl_pkg::CMD_SRX, 4'h0, 18'h0, 60);
  endtask
  // a bank left open in 2x mode while refreshes fall due; the controller must step in
  task automatic t_urgent;
    int r0;
    refMode = 2'h1;
    send(ddr4_ctl_pkg::CMD_ACT, 4'h3, 18'h00123, 200);
    r0 = nRef;
    for (int i = 0; i < 18000 && nRef == r0; i++) idle(1);
    idle(20);
    chk(took && nRef == r0 + 1 && bankOpen === 16'h0 && nErr == 0, "forced refresh");
    chk(postponed === 7'sh0F && readOk === 1'b1, "owed count after force");
  endtask
  // ----------------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------------
  // the forced refresh alone needs about 15600 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      $display("MISMATCH %0t timeout", $time);
      complete_run;
    end
  end
  initial
  begin
    idle(8);
    resetn = 1;
    idle(2);
    t_reset;
    t_act_pre;
    t_refresh;
    t_selfref;
    t_urgent;
    complete_run;
  end
endmodule // ddr4_bank_refresh_ctl_tb
`default_nettype wire

//--- dv/ddr4_dev_model.sv
`default_nettype none
module ddr4_dev_model (
  input  wire logic        ckT,   // memory clock, true side
  input  wire logic        cke,   // clock enable
  input  wire logic        csN,   // chip select, low active
  input  wire logic        actN,  // activate, low active
  input  wire logic [17:0] row,   // row pins reassembled
  input  wire logic [3:0]  bank,  // bank group and bank
  output logic [15:0]      rowOpen, // open row per bank
  output logic [17:0]      lastRow, // row of last activate
  output logic [3:0]       lastBank, // bank of last activate
  output int               nRef,  // refreshes seen
  output int               nErr,  // protocol faults seen
  output int               nInt,  // self-refresh entries seen
  output logic             srMode, // in self-refresh
  output logic             termOn, // termination enabled
  output logic             dllOn  // dll running
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime refAt;        // time of last refresh
  realtime srxAt;        // time of last self-refresh exit
  realtime preAt [16];   // time of last precharge per bank
  initial
  begin
    rowOpen = '0; nRef = 0; nErr = 0; nInt = 0; srMode = 0; termOn = 1; dllOn = 1;
    refAt = -1000.0;
    srxAt = -1000.0;
    foreach (preAt[i]) preAt[i] = -1000.0;
  end
  // ----------------------------------------------------------------
  // command decode at the clock's rising edge, exit on cke rising
  // ----------------------------------------------------------------
  // one process owns the mode flags; the clock may be stopped at exit
  always @(posedge ckT or posedge cke)
  begin
    if (srMode)
    begin
      // only cke counts in self-refresh
      if (cke)
      begin
        srMode = 0;
        termOn = 1;
        dllOn = 1;
        srxAt = $realtime;
      end
    end
    else if (ckT && !csN)
    begin
      // deselect only inside tRFC, and inside tXS after exit
      if ($realtime - refAt < 350.0 || $realtime - srxAt < 360.0) nErr++;
      if (!actN)
      begin
        if (rowOpen[bank] || $realtime - preAt[bank] < 14.0) nErr++;
        rowOpen[bank] = 1'b1;
        lastRow = row;
        lastBank = bank;
      end
      else if (row[16:14] == 3'h2)
      begin
        // precharge of an idle bank still restarts its timer
        for (int b = 0; b < 16; b++)
          if (row[10] || b == bank) begin rowOpen[b] = 1'b0; preAt[b] = $realtime; end
      end
      else if (row[16:14] == 3'h1)
      begin
        if (rowOpen != '0) nErr++;
        if (cke) begin nRef++; refAt = $realtime; end
        else begin srMode = 1; termOn = 0; dllOn = 0; nInt++; end
      end
    end
  end
endmodule // ddr4_dev_model
`default_nettype wire

//--- src/ddr4_bank_refresh_ctl.sv
`include "ddr4_ctl_defs.svh"
`default_nettype none
module ddr4_bank_refresh_ctl #(
  parameter int CK_HALF = 2,   // core cycles per half period of the memory clock
  parameter bit X16     = 1'b0 // one group bit only on wide parts
) (
  input  wire logic                 core_clk,    // core clock
  input  wire logic                 resetn,      // async reset, active low
  input  wire logic                 reqValid,    // request present
  output logic                      reqReady,    // request taken this cycle
  input  wire ddr4_ctl_pkg::cmd_e   reqCmd,      // request command
  input  wire logic [1:0]           reqBg,       // bank group
  input  wire logic [1:0]           reqBa,       // bank in group
  input  wire logic [17:0]          reqRow,      // row address
  input  wire logic [1:0]           refMode,     // 0 1x, 1 2x, 2 4x
  output logic [15:0]               bankOpen,    // open row per bank
  output logic signed [6:0]         postponed,   // refreshes owed
  output logic                      srActive,    // in self-refresh
  output logic                      readOk,      // locked-DLL commands allowed
  output logic                      ddrCkT,      // memory clock true
  output logic                      ddrCkC,      // memory clock complement
  output logic                      ddrCke,      // clock enable
  output logic                      ddrCsN,      // chip select, low active
  output logic                      ddrActN,     // activate, low active
  output logic                      ddrRasNA16,  // ras / row bit 16
  output logic                      ddrCasNA15,  // cas / row bit 15
  output logic                      ddrWeNA14,   // we / row bit 14
  output logic                      ddrA17,      // row bit 17
  output logic [13:0]               ddrAddr,     // address bits 0..13
  output logic [1:0]                ddrBg,       // bank group pins
  output logic [1:0]                ddrBa,       // bank pins
  output logic                      ddrOdt,      // termination control
  output logic                      ddrResetN    // device reset, low active
);
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  RP_CYC    = 8'(`CYC_MIN(`T_RP_NS));
  localparam logic [11:0] RFC_CYC   = 12'(`CYC_MIN(`T_RFC_NS));
  localparam logic [11:0] XS_CYC    = 12'(`CYC_MIN(`T_XS_NS));
  localparam logic [11:0] REFI_CYC  = 12'(`CYC_MAX(`T_REFI_NS));
  localparam logic [11:0] XSDLL_CYC = 12'(`CYC_MIN(`T_XSDLL_NS));
  localparam logic [7:0]  CKESR_CYC = 8'(`CYC_MIN(`T_CKESR_NS));
  localparam logic [7:0]  CKSRE_CYC = 8'(`CYC_MIN(`T_CKSRE_NS));
  localparam logic [7:0]  CKSRX_CYC = 8'(`CYC_MIN(`T_CKSRX_NS));
  localparam logic [7:0]  HALF_LAST = 8'(CK_HALF - 1);

  // memory clock period in core cycles; the entry check waits exactly this long
  localparam int SLOT_GAP = 2 * CK_HALF;

  // divider counter is eight bits wide; the entry check delay caps it lower
  if (CK_HALF < 1 || CK_HALF > 150)
  begin : g_bad_half
    $error("CK_HALF out of range");
  end

  // bank index: wide parts use only the low group bit
  function automatic logic [3:0] bankIdx(input logic [1:0] bg, input logic [1:0] ba);
    return X16 ? {1'b0, bg[0], ba} : {bg, ba};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ddr4_ctl_pkg::state_e state;     // sequencer state
  logic [7:0]           ckDiv;     // half period counter
  logic                 ckRun;     // memory clock running
  logic [11:0]          busyCnt;   // tRFC / tXS hold-off
  logic [11:0]          refiCnt;   // average interval timer
  logic [11:0]          dllCnt;    // tXSDLL timer
  logic [7:0]           srTmr;     // tCKSRE / tCKSRX timer
  logic [7:0]           esrTmr;    // tCKESR residency timer
  logic                 needRef;   // extra refresh owed after exit
  logic                 prevDes;   // last slot was deselect
  logic [15:0]          tmrZero;   // per bank tRP done

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire stRun  = (state == ddr4_ctl_pkg::ST_RUN);
  wire stIdle = (state == ddr4_ctl_pkg::ST_IDLE);
  // slot: the memory clock falls next, so commands get half a period of setup
  wire slot   = ckRun && ddrCkT && (ckDiv == HALF_LAST);
  wire [1:0] modeSh = (refMode == 2'h3) ? 2'h2 : refMode;
  wire signed [6:0] limit = 7'(`POSTPONE_1X << modeSh);
  wire [11:0] refiLen = REFI_CYC >> modeSh;
  wire [3:0]  rb      = bankIdx(reqBg, reqBa);
  wire allIdle   = (bankOpen == 16'h0000) && (&tmrZero);
  wire canIssue  = stRun && slot && (busyCnt == 12'h000);
  wire urgent    = (postponed >= limit);
  wire forcePrea = canIssue && urgent && (bankOpen != 16'h0000);
  wire forceRef  = canIssue && urgent && allIdle;
  wire actLegal  = !bankOpen[rb] && tmrZero[rb];
  wire refLegal  = allIdle && (postponed > -limit);
  wire sreLegal  = allIdle && prevDes && !needRef;
  wire reqLegal  = (reqCmd == ddr4_ctl_pkg::CMD_ACT)  ? actLegal :
                   (reqCmd == ddr4_ctl_pkg::CMD_PRE)  ? 1'b1 :
                   (reqCmd == ddr4_ctl_pkg::CMD_PREA) ? 1'b1 :
                   (reqCmd == ddr4_ctl_pkg::CMD_REF)  ? refLegal :
                   (reqCmd == ddr4_ctl_pkg::CMD_SRE)  ? sreLegal : 1'b0;
  wire srxReady  = (reqCmd == ddr4_ctl_pkg::CMD_SRX) && stIdle && (esrTmr == 8'h00);
  assign reqReady = (canIssue && !urgent && reqLegal) || srxReady;
  wire take      = reqValid && reqReady;
  wire userAct   = take && (reqCmd == ddr4_ctl_pkg::CMD_ACT);
  wire userPre   = take && (reqCmd == ddr4_ctl_pkg::CMD_PRE);
  wire userPrea  = take && (reqCmd == ddr4_ctl_pkg::CMD_PREA);
  wire userRef   = take && (reqCmd == ddr4_ctl_pkg::CMD_REF);
  wire userSre   = take && (reqCmd == ddr4_ctl_pkg::CMD_SRE);
  wire userSrx   = take && (reqCmd == ddr4_ctl_pkg::CMD_SRX);
  wire preAll    = forcePrea || userPrea;
  wire issuePre  = preAll || userPre;
  wire issueRef  = forceRef || userRef;
  wire cmdAny    = userAct || issuePre || issueRef || userSre;
  wire tick      = stRun && (refiCnt == 12'h000);
  wire wakeDone  = (state == ddr4_ctl_pkg::ST_WAKE) && (srTmr == 8'h00) && slot;

  // next pin values; deselect leaves the code lines high
  wire next_csN  = !cmdAny;
  wire next_actN = !userAct;
  // refresh and self-refresh entry share a code: ras/cas low, we/act high
  wire next_ras  = userAct ? reqRow[16] : !cmdAny;
  wire next_cas  = userAct ? reqRow[15] : (issuePre || !cmdAny);
  wire next_we   = userAct ? reqRow[14] : !issuePre;
  wire [13:0] next_addr = userAct ? reqRow[13:0] :
                          (preAll ? 14'(1 << `A10_AP_BIT) : 14'h0000);
  wire signed [6:0] next_post = postponed + (tick ? 7'sd1 : 7'sd0) - (issueRef ? 7'sd1 : 7'sd0);

  // ----------------------------------------------------------------
  // per bank state and tRP timers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_bank
      logic [7:0] tmr;  // precharge time left
      wire preHit = issuePre && (preAll || (rb == 4'(g)));
      wire actHit = userAct && (rb == 4'(g));
      // every precharge restarts the period, idle or not
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          tmr <= 8'h00;
        else if (preHit)
          tmr <= RP_CYC;
        else if (tmr != 8'h00)
          tmr <= tmr - 8'h01;
      end
      // open on activate, closed on precharge
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          bankOpen[g] <= 1'b0;
        else if (actHit)
          bankOpen[g] <= 1'b1;
        else if (preHit)
          bankOpen[g] <= 1'b0;
      end
      assign tmrZero[g] = (tmr == 8'h00);
    end
  endgenerate

  // ----------------------------------------------------------------
  // memory clock divider; held low while stopped
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ckDiv  <= 8'h00;
      ddrCkT <= 1'b0;
      ddrCkC <= 1'b1;
    end
    else if (!ckRun)
    begin
      ckDiv  <= 8'h00;
      ddrCkT <= 1'b0;
      ddrCkC <= 1'b1;
    end
    else if (ckDiv == HALF_LAST)
    begin
      ckDiv  <= 8'h00;
      ddrCkT <= !ddrCkT;
      ddrCkC <= ddrCkT;
    end
    else
      ckDiv <= ckDiv + 8'h01;
  end

  // ----------------------------------------------------------------
  // command pins, updated only at a slot
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ddrCsN <= 1'b1;
      ddrActN <= 1'b1;
      ddrRasNA16 <= 1'b1;
      ddrCasNA15 <= 1'b1;
      ddrWeNA14 <= 1'b1;
      ddrA17 <= 1'b0;
      ddrAddr <= 14'h0000;
      ddrBg <= 2'h0;
      ddrBa <= 2'h0;
      prevDes <= 1'b1;
    end
    else if (slot)
    begin
      ddrCsN <= next_csN;
      ddrActN <= next_actN;
      ddrRasNA16 <= next_ras;
      ddrCasNA15 <= next_cas;
      ddrWeNA14 <= next_we;
      ddrA17 <= userAct && reqRow[17];
      ddrAddr <= next_addr;
      ddrBg <= reqBg;
      ddrBa <= reqBa;
      prevDes <= next_csN;
    end
  end

  // ----------------------------------------------------------------
  // refresh bookkeeping
  // ----------------------------------------------------------------
  // the interval timer is held at refiLen in self-refresh; the device refreshes itself there
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refiCnt <= REFI_CYC;
      postponed <= 7'sd0;
      busyCnt <= 12'h000;
      dllCnt <= 12'h000;
      needRef <= 1'b0;
      readOk <= 1'b1;
    end
    else
    begin
      refiCnt <= tick ? refiLen : (stRun ? refiCnt - 12'h001 : refiLen);
      postponed <= wakeDone ? 7'sd0 : next_post;
      if (issueRef)
        busyCnt <= RFC_CYC;
      else if (wakeDone)
        busyCnt <= XS_CYC;
      else if (busyCnt != 12'h000)
        busyCnt <= busyCnt - 12'h001;
      dllCnt <= wakeDone ? XSDLL_CYC : ((dllCnt != 12'h000) ? dllCnt - 12'h001 : 12'h000);
      readOk <= stRun && !wakeDone && (dllCnt == 12'h000);
      // set on exit wins over the clear of a refresh in the same cycle
      needRef <= wakeDone || (needRef && !issueRef);
    end
  end

  // ----------------------------------------------------------------
  // self-refresh sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ddr4_ctl_pkg::ST_RUN;
      ckRun <= 1'b1;
      ddrCke <= 1'b1;
      srActive <= 1'b0;
      srTmr <= 8'h00;
      esrTmr <= 8'h00;
      ddrResetN <= 1'b0;
    end
    else
    begin
      ddrResetN <= 1'b1;
      if (esrTmr != 8'h00)
        esrTmr <= esrTmr - 8'h01;
      if (srTmr != 8'h00)
        srTmr <= srTmr - 8'h01;
      case (state)
        ddr4_ctl_pkg::ST_RUN:
        begin
          if (userSre)
          begin
            state <= ddr4_ctl_pkg::ST_ENT;
            ddrCke <= 1'b0;
            srActive <= 1'b1;
            srTmr <= CKSRE_CYC;
            esrTmr <= CKESR_CYC;
          end
        end
        ddr4_ctl_pkg::ST_ENT:
        begin
          // stop only at a falling edge, after the deselect slot
          if ((srTmr == 8'h00) && slot && !prevDes == 1'b0)
          begin
            state <= ddr4_ctl_pkg::ST_IDLE;
            ckRun <= 1'b0;
          end
        end
        ddr4_ctl_pkg::ST_IDLE:
        begin
          if (userSrx)
          begin
            state <= ddr4_ctl_pkg::ST_WAKE;
            ckRun <= 1'b1;
            srTmr <= CKSRX_CYC;
          end
        end
        ddr4_ctl_pkg::ST_WAKE:
        begin
          // pins already deselect, so cke rise alone forms the exit
          if (wakeDone)
          begin
            state <= ddr4_ctl_pkg::ST_RUN;
            ddrCke <= 1'b1;
            srActive <= 1'b0;
          end
        end
        default:
          state <= ddr4_ctl_pkg::ST_RUN;
      endcase
    end
  end

  // termination pin stays low, as exit needs it low through tXSDLL
  assign ddrOdt = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence sreSlot;
    userSre;
  endsequence
  // the very next slot must carry deselect, not merely some later one
  sequence desNextSlot;
    slot ##1 ddrCsN;
  endsequence

  ref_banks_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    issueRef |-> (bankOpen == 16'h0000) && (&tmrZero))
    else $error("refresh with a bank not idle");
  ref_trfc_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    issueRef |=> (busyCnt == RFC_CYC) ##1 (!reqReady || srxReady) [*3])
    else $error("command allowed inside tRFC");
  post_limit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    postponed <= limit)
    else $error("too many refreshes postponed");
  pull_limit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    postponed >= -limit)
    else $error("refresh pulled in beyond credit");
  sre_des_around_a: assert property (@(posedge core_clk) disable iff (!resetn)
    sreSlot |-> (prevDes && !needRef) ##SLOT_GAP desNextSlot)
    else $error("self-refresh entry without deselect around it");
  cke_low_sr_a: assert property (@(posedge core_clk) disable iff (!resetn)
    srActive && !$rose(ddrCke) |-> !ddrCke || $past(wakeDone))
    else $error("cke high during self-refresh");
  act_bank_ok_a: assert property (@(posedge core_clk) disable iff (!resetn)
    userAct |-> !bankOpen[rb] && tmrZero[rb] ##1 bankOpen[$past(rb)])
    else $error("activate to open or precharging bank");
  xs_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(ddrCke) |-> (busyCnt == XS_CYC) && ddrCsN && (dllCnt == XSDLL_CYC))
    else $error("exit timers not loaded");
  ck_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(ckRun) |-> !ddrCke && ($past(srTmr) == 8'h00))
    else $error("clock stopped too early");
endmodule // ddr4_bank_refresh_ctl
`default_nettype wire

//--- src/ddr4_ctl_defs.svh
`ifndef DDR4_CTL_DEFS_SVH
`define DDR4_CTL_DEFS_SVH
// ----------------------------------------------------------------
// core clock and cycle conversion
// ----------------------------------------------------------------
`define CORE_PERIOD_NS 4
// least times round up, never below one cycle
`define CYC_MIN(ns) ((((ns) + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS) < 1 ? 1 : \
                     (((ns) + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS))
// longest times round down, never below one cycle
`define CYC_MAX(ns) (((ns) / `CORE_PERIOD_NS) < 1 ? 1 : ((ns) / `CORE_PERIOD_NS))
// ----------------------------------------------------------------
// device timing in ns
// ----------------------------------------------------------------
`define T_RP_NS        14
`define T_RFC_NS       350
`define T_XS_EXTRA_NS  10
`define T_XS_NS        (`T_RFC_NS + `T_XS_EXTRA_NS)
`define T_REFI_NS      7800
`define T_XSDLL_NS     12288
`define T_CKESR_NS     24
`define T_CKSRE_NS     10
`define T_CKSRX_NS     10
// ----------------------------------------------------------------
// field positions and limits
// ----------------------------------------------------------------
`define A10_AP_BIT     10
`define POSTPONE_1X    8
`endif

//--- src/ddr4_ctl_pkg.sv
`default_nettype none
package ddr4_ctl_pkg;
  // ----------------------------------------------------------------
  // user request commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_ACT  = 3'h0,  // open a row
    CMD_PRE  = 3'h1,  // close one bank
    CMD_PREA = 3'h2,  // close all banks
    CMD_REF  = 3'h3,  // refresh
    CMD_SRE  = 3'h4,  // enter self-refresh
    CMD_SRX  = 3'h5   // leave self-refresh
  } cmd_e;
  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,  // normal operation
    ST_ENT  = 4'h2,  // self-refresh entered, clock still running
    ST_IDLE = 4'h4,  // self-refresh, clock stopped
    ST_WAKE = 4'h8   // clock restarted, waiting to raise cke
  } state_e;
endpackage
`default_nettype wire
